// [core/dual_timer_pkg.sv]
// Constants shared by the dual 8-bit compare timer.
package dual_timer_pkg;
   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] CH_STRIDE = 8'h20;
   localparam logic [7:0] OFF_COUNTER = 8'h00;
   localparam logic [7:0] OFF_CONST_A = 8'h04;
   localparam logic [7:0] OFF_CONST_B = 8'h08;
   localparam logic [7:0] OFF_CONTROL = 8'h0C;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_WORD_COUNTER = 8'h40;
   localparam logic [7:0] OFF_WORD_CONST_A = 8'h44;
   localparam logic [7:0] OFF_WORD_CONST_B = 8'h48;
   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] COUNTER_RESET = 8'h00;
   localparam logic [7:0] CONST_RESET = 8'hFF;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] COUNT_TOP = 8'hFF;
   // ----------------------------------------------------------------
   // Control field positions
   // ----------------------------------------------------------------
   localparam int B_IE = 7;
   localparam int A_IE = 6;
   localparam int W_IE = 5;
   localparam int CLR_HI = 4;
   localparam int CLR_LO = 3;
   localparam int CKS_HI = 2;
   // Status field positions
   localparam int B_FLAG = 7;
   localparam int A_FLAG = 6;
   localparam int W_FLAG = 5;
   localparam int OSB_HI = 3;
   localparam int OSA_HI = 1;
   // ----------------------------------------------------------------
   // Mode encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {CLR_NONE = 2'h0, CLR_MATCH_A = 2'h1,
      CLR_MATCH_B = 2'h2, CLR_EXT_PIN = 2'h3} clear_sel_t;
   typedef enum logic [1:0] {OUT_KEEP = 2'h0, OUT_LOW = 2'h1,
      OUT_HIGH = 2'h2, OUT_TOGGLE = 2'h3} out_sel_t;
   typedef enum logic [2:0] {CK_STOP = 3'h0, CK_DIV8 = 3'h1, CK_DIV64 = 3'h2,
      CK_DIV8192 = 3'h3, CK_CASCADE = 3'h4, CK_EXT_RISE = 3'h5,
      CK_EXT_FALL = 3'h6, CK_EXT_BOTH = 3'h7} clock_sel_t;
   // Prescaler taps: log2 of each divisor
   localparam int DIV8_LOG = 3;
   localparam int DIV64_LOG = 6;
   localparam int DIV8192_LOG = 13;
endpackage : dual_timer_pkg

// [core/prescale_if.sv]
// Prescaler tick bundle between the divider and the timer channels.
`timescale 1ns/1ps
`default_nettype none
interface prescale_if;
   logic tick8;    // One pclk pulse per 8 cycles
   logic tick64;   // One pclk pulse per 64 cycles
   logic tick8192; // One pclk pulse per 8192 cycles
   modport src (output tick8, output tick64, output tick8192);
   modport snk (input tick8, input tick64, input tick8192);
endinterface : prescale_if
`default_nettype wire

// [core/timer_prescaler.sv]
// Free-running divider that marks the falling edges of the divided clocks.
`timescale 1ns/1ps
`default_nettype none
module timer_prescaler
   import dual_timer_pkg::*;
#(
   parameter int DIV_W = DIV8192_LOG
)(
   input wire logic pclk,      // System clock
   input wire logic presetn,   // Async reset, active low
   input wire logic ce,        // Clock enable
   prescale_if.src ticks       // Divided-clock pulses
);
   logic [DIV_W-1:0] div_q;

   // ----------------------------------------------------------------
   // Divider and edge pulses
   // ----------------------------------------------------------------
   // A tap falls when all bits below and at it are ones before the step
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_q <= '0;
         ticks.tick8 <= 1'b0;
         ticks.tick64 <= 1'b0;
         ticks.tick8192 <= 1'b0;
      end
      else if (ce)
      begin
         div_q <= div_q + 1'b1;
         ticks.tick8 <= &div_q[DIV8_LOG-1:0];
         ticks.tick64 <= &div_q[DIV64_LOG-1:0];
         ticks.tick8192 <= &div_q[DIV8192_LOG-1:0];
      end
   end
endmodule : timer_prescaler
`default_nettype wire

// [core/dual_compare_timer.sv]
// Two-channel 8-bit compare timer with APB register access.
//
// Operation
// - Each channel has an 8-bit up-counter, zero at reset, stepping on count edges.
// - Counter and constant pairs also readable/writable as one 16-bit word.
// - Counter wrap from all ones to zero sets the wrap flag.
// - Constant A equal to counter sets match A flag.
// - Constant B equal to counter sets match B flag.
// - A write to a constant register suppresses its compare that cycle.
// - Constants A and B are 8-bit read/write, all ones at reset.
// - Each request is high one cycle after its flag and its enable bit are both set.
// - Clear select: none, match A, match B, external pin rising edge.
// - Clock select 000 stops; 001-011 count divide-by-8, 64, 8192.
// - Code 100: channel 0 counts channel 1 wraps; channel 1 counts channel 0 match A.
// - Codes 101-111 count external clock rising, falling or both edges.
// - Flags clear only by writing 0 after reading 1; writing 1 does nothing.
// - Status bit 4 is reserved, ignores writes.
// - Match B drives pin: keep, low, high or toggle.
// - Match A also drives the pin through its own select field.
// - Each channel has an output pin, external clock and clear inputs.
// - In 16-bit mode channel 0 is the upper byte, channel 1 the lower.
// - Select A codes: keep, low, high, toggle on match A.
// - 16-bit mode: channel 0 uses full match; channel 1 lower byte, clear ignored.
// - Match fires in the last cycle of equality, with the next count edge.
// - Counter write beats a count edge in the same cycle.
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module dual_compare_timer
   import dual_timer_pkg::*;
(
   input wire logic pclk,               // System clock
   input wire logic presetn,            // Async reset, active low
   input wire logic ce,                 // Clock enable, freezes state when low
   input wire logic [7:0] paddr,        // APB address
   input wire logic psel,               // APB select
   input wire logic penable,            // APB enable
   input wire logic pwrite,             // APB direction
   input wire logic [31:0] pwdata,      // APB write data
   output logic [31:0] prdata,          // APB read data
   output logic pready,                 // APB ready
   output logic pslverr,                // APB error on unmapped address
   input wire logic [1:0] ext_clock_in, // External count pins, index = channel
   input wire logic [1:0] ext_clear_in, // External clear pins
   output logic [1:0] timer_out,        // Compare-driven pins
   output logic [1:0] match_a_request,  // Match A requests
   output logic [1:0] match_b_request,  // Match B requests
   output logic [1:0] wrap_request      // Wrap requests
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] counter_value_q [2];
   logic [7:0] constant_a_q [2];
   logic [7:0] constant_b_q [2];
   logic [7:0] timer_control_q [2];
   logic [3:0] out_select_q [2];
   logic [1:0] match_b_flag_q, match_a_flag_q, wrap_flag_q;
   logic [1:0] arm_b_q, arm_a_q, arm_w_q;
   logic [1:0] ck_s1_q, ck_s2_q, ck_s3_q, rs_s1_q, rs_s2_q, rs_s3_q;
   prescale_if pre ();

   timer_prescaler #(.DIV_W(DIV8192_LOG)) u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .ticks(pre)
   );

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Tick from the prescaler or external pin for a clock-select code
   function automatic logic src_tick(input logic [2:0] sel, input logic t8,
      input logic t64, input logic t8192, input logic rise, input logic fall);
      logic t;
      t = 1'b0;
      case (clock_sel_t'(sel))
         CK_DIV8: t = t8;
         CK_DIV64: t = t64;
         CK_DIV8192: t = t8192;
         CK_EXT_RISE: t = rise;
         CK_EXT_FALL: t = fall;
         CK_EXT_BOTH: t = rise | fall;
         default: t = 1'b0;
      endcase
      return t;
   endfunction : src_tick

   // Next pin level from both match events and their select fields
   function automatic logic pin_next(input logic cur, input logic ma,
      input logic mb, input logic [1:0] sa, input logic [1:0] sb);
      logic lo, hi, tg;
      lo = (ma && sa == OUT_LOW) || (mb && sb == OUT_LOW);
      hi = (ma && sa == OUT_HIGH) || (mb && sb == OUT_HIGH);
      tg = (ma && sa == OUT_TOGGLE) || (mb && sb == OUT_TOGGLE);
      if (lo)
         return 1'b0;
      else if (hi)
         return 1'b1;
      else if (tg)
         return ~cur;
      return cur;
   endfunction : pin_next

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // Third stage only feeds edge detection, never the first stage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ck_s1_q <= '0;
         ck_s2_q <= '0;
         ck_s3_q <= '0;
         rs_s1_q <= '0;
         rs_s2_q <= '0;
         rs_s3_q <= '0;
      end
      else if (ce)
      begin
         ck_s1_q <= ext_clock_in;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
         rs_s1_q <= ext_clear_in;
         rs_s2_q <= rs_s1_q;
         rs_s3_q <= rs_s2_q;
      end
   end

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic setup, access;
   logic [7:0] rel;
   logic sel_ch;
   logic hit_cnt, hit_ca, hit_cb, hit_ctl, hit_st, hit_w16;
   logic w_cnt, w_ca, w_cb, mapped;
   logic [1:0] wr_cnt, wr_ca, wr_cb, wr_ctl, wr_st;
   logic [7:0] wd [2];

   assign setup = psel && !penable;
   assign access = psel && penable && pready;

   // Per-channel window or the paired-word window
   always_comb
   begin
      sel_ch = (paddr >= CH_STRIDE) && (paddr < OFF_WORD_COUNTER);
      rel = sel_ch ? paddr - CH_STRIDE : paddr;
      hit_cnt = 1'b0;
      hit_ca = 1'b0;
      hit_cb = 1'b0;
      hit_ctl = 1'b0;
      hit_st = 1'b0;
      w_cnt = 1'b0;
      w_ca = 1'b0;
      w_cb = 1'b0;
      if (paddr == OFF_WORD_COUNTER)
         w_cnt = 1'b1;
      else if (paddr == OFF_WORD_CONST_A)
         w_ca = 1'b1;
      else if (paddr == OFF_WORD_CONST_B)
         w_cb = 1'b1;
      else if (paddr < OFF_WORD_COUNTER && rel == OFF_COUNTER)
         hit_cnt = 1'b1;
      else if (paddr < OFF_WORD_COUNTER && rel == OFF_CONST_A)
         hit_ca = 1'b1;
      else if (paddr < OFF_WORD_COUNTER && rel == OFF_CONST_B)
         hit_cb = 1'b1;
      else if (paddr < OFF_WORD_COUNTER && rel == OFF_CONTROL)
         hit_ctl = 1'b1;
      else if (paddr < OFF_WORD_COUNTER && rel == OFF_STATUS)
         hit_st = 1'b1;
      hit_w16 = w_cnt || w_ca || w_cb;
      mapped = hit_w16 || hit_cnt || hit_ca || hit_cb || hit_ctl || hit_st;
   end

   // Write strobes at the completing access edge; word writes hit both
   always_comb
   begin
      wd[0] = hit_w16 ? pwdata[15:8] : pwdata[7:0];
      wd[1] = pwdata[7:0];
      for (int c = 0; c < 2; c++)
      begin
         wr_cnt[c] = access && pwrite && ((hit_cnt && sel_ch == c[0]) || w_cnt);
         wr_ca[c] = access && pwrite && ((hit_ca && sel_ch == c[0]) || w_ca);
         wr_cb[c] = access && pwrite && ((hit_cb && sel_ch == c[0]) || w_cb);
         wr_ctl[c] = access && pwrite && hit_ctl && sel_ch == c[0];
         wr_st[c] = access && pwrite && hit_st && sel_ch == c[0];
      end
   end

   // ----------------------------------------------------------------
   // Count sources, matches and clears
   // ----------------------------------------------------------------
   logic [2:0] cks [2];
   logic [1:0] clr_sel [2];
   logic [1:0] base, tick, eq_a, eq_b, m_a, m_b, clr, wrap;
   logic mode16, cmc, m_a0_plain;

   always_comb
   begin
      for (int c = 0; c < 2; c++)
      begin
         cks[c] = timer_control_q[c][CKS_HI -: 3];
         clr_sel[c] = timer_control_q[c][CLR_HI:CLR_LO];
         base[c] = src_tick(cks[c], pre.tick8, pre.tick64, pre.tick8192,
            ck_s2_q[c] && !ck_s3_q[c], !ck_s2_q[c] && ck_s3_q[c]);
         eq_a[c] = counter_value_q[c] == constant_a_q[c];
         eq_b[c] = counter_value_q[c] == constant_b_q[c];
      end
      mode16 = cks[0] == CK_CASCADE;
      cmc = cks[1] == CK_CASCADE;
      // Channel 0 match A from its own sources feeds the match-count mode
      m_a0_plain = eq_a[0] && base[0] && !wr_ca[0];
      // Both cascaded at once gives no count clock for either channel
      tick[1] = cmc ? (m_a0_plain && !mode16) : base[1];
      m_a[1] = eq_a[1] && tick[1] && !wr_ca[1];
      m_b[1] = eq_b[1] && tick[1] && !wr_cb[1];
      if (mode16)
      begin
         // Full 16-bit match, taken at the low byte's count edge
         m_a[0] = eq_a[0] && eq_a[1] && tick[1] && !wr_ca[0] && !cmc;
         m_b[0] = eq_b[0] && eq_b[1] && tick[1] && !wr_cb[0] && !cmc;
      end
      else
      begin
         m_a[0] = m_a0_plain;
         m_b[0] = eq_b[0] && base[0] && !wr_cb[0];
      end
      for (int c = 0; c < 2; c++)
      begin
         case (clear_sel_t'(clr_sel[c]))
            CLR_MATCH_A: clr[c] = m_a[c];
            CLR_MATCH_B: clr[c] = m_b[c];
            CLR_EXT_PIN: clr[c] = rs_s2_q[c] && !rs_s3_q[c];
            default: clr[c] = 1'b0;
         endcase
      end
      if (mode16)
      begin
         // Low byte follows the 16-bit match clears, not an external pin clear; its own setting is ignored
         clr[1] = clr[0] && clear_sel_t'(clr_sel[0]) != CLR_EXT_PIN;
      end
      wrap[1] = tick[1] && counter_value_q[1] == COUNT_TOP && !clr[1] && !wr_cnt[1];
      tick[0] = mode16 ? (wrap[1] && !cmc) : base[0];
      wrap[0] = tick[0] && counter_value_q[0] == COUNT_TOP && !clr[0] && !wr_cnt[0];
   end

   // ----------------------------------------------------------------
   // Counters and constants
   // ----------------------------------------------------------------
   // Clear beats a write, a write beats a count edge
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int c = 0; c < 2; c++)
            counter_value_q[c] <= COUNTER_RESET;
      end
      else if (ce)
      begin
         for (int c = 0; c < 2; c++)
         begin
            if (clr[c])
               counter_value_q[c] <= COUNTER_RESET;
            else if (wr_cnt[c])
               counter_value_q[c] <= wd[c];
            else if (tick[c])
               counter_value_q[c] <= counter_value_q[c] + 8'h01;
         end
      end
   end

   // Constant and control registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int c = 0; c < 2; c++)
         begin
            constant_a_q[c] <= CONST_RESET;
            constant_b_q[c] <= CONST_RESET;
            timer_control_q[c] <= CONTROL_RESET;
            out_select_q[c] <= '0;
         end
      end
      else if (ce)
      begin
         for (int c = 0; c < 2; c++)
         begin
            if (wr_ca[c])
               constant_a_q[c] <= wd[c];
            if (wr_cb[c])
               constant_b_q[c] <= wd[c];
            if (wr_ctl[c])
               timer_control_q[c] <= wd[c];
            if (wr_st[c])
               out_select_q[c] <= wd[c][OSB_HI:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Flags: armed by a read of one, cleared by a later write of zero
   // ----------------------------------------------------------------
   logic rd_st;
   assign rd_st = access && !pwrite && hit_st;

   // Hardware set wins over a same-cycle software clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         match_b_flag_q <= '0;
         match_a_flag_q <= '0;
         wrap_flag_q <= '0;
         arm_b_q <= '0;
         arm_a_q <= '0;
         arm_w_q <= '0;
      end
      else if (ce)
      begin
         for (int c = 0; c < 2; c++)
         begin
            if (m_b[c])
               match_b_flag_q[c] <= 1'b1;
            else if (wr_st[c] && arm_b_q[c] && !wd[c][B_FLAG])
               match_b_flag_q[c] <= 1'b0;
            if (m_a[c])
               match_a_flag_q[c] <= 1'b1;
            else if (wr_st[c] && arm_a_q[c] && !wd[c][A_FLAG])
               match_a_flag_q[c] <= 1'b0;
            if (wrap[c])
               wrap_flag_q[c] <= 1'b1;
            else if (wr_st[c] && arm_w_q[c] && !wd[c][W_FLAG])
               wrap_flag_q[c] <= 1'b0;
            if (rd_st && sel_ch == c[0])
            begin
               arm_b_q[c] <= match_b_flag_q[c];
               arm_a_q[c] <= match_a_flag_q[c];
               arm_w_q[c] <= wrap_flag_q[c];
            end
            else if (wr_st[c])
            begin
               arm_b_q[c] <= 1'b0;
               arm_a_q[c] <= 1'b0;
               arm_w_q[c] <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Pins and requests
   // ----------------------------------------------------------------
   // Requests follow the flags one cycle later, gated by enables
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timer_out <= '0;
         match_a_request <= '0;
         match_b_request <= '0;
         wrap_request <= '0;
      end
      else if (ce)
      begin
         for (int c = 0; c < 2; c++)
         begin
            timer_out[c] <= pin_next(timer_out[c], m_a[c], m_b[c],
               out_select_q[c][OSA_HI:0], out_select_q[c][OSB_HI:OSA_HI+1]);
            match_b_request[c] <= match_b_flag_q[c] && timer_control_q[c][B_IE];
            match_a_request[c] <= match_a_flag_q[c] && timer_control_q[c][A_IE];
            wrap_request[c] <= wrap_flag_q[c] && timer_control_q[c][W_IE];
         end
      end
   end

   // ----------------------------------------------------------------
   // APB answer: no wait state, data captured in the setup cycle
   // ----------------------------------------------------------------
   logic [7:0] rb;
   logic ch;
   always_comb
   begin
      ch = sel_ch;
      rb = '0;
      if (hit_cnt)
         rb = counter_value_q[ch];
      else if (hit_ca)
         rb = constant_a_q[ch];
      else if (hit_cb)
         rb = constant_b_q[ch];
      else if (hit_ctl)
         rb = timer_control_q[ch];
      else if (hit_st)
         rb = {match_b_flag_q[ch], match_a_flag_q[ch], wrap_flag_q[ch], 1'b0,
            out_select_q[ch]};
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end
      else if (ce)
      begin
         pready <= setup;
         pslverr <= setup && !mapped;
         if (setup && !pwrite)
         begin
            if (w_cnt)
               prdata <= {16'h0000, counter_value_q[0], counter_value_q[1]};
            else if (w_ca)
               prdata <= {16'h0000, constant_a_q[0], constant_a_q[1]};
            else if (w_cb)
               prdata <= {16'h0000, constant_b_q[0], constant_b_q[1]};
            else
               prdata <= {24'h000000, rb};
         end
      end
   end
endmodule : dual_compare_timer
`default_nettype wire

// [bench/dual_compare_timer_chk.sv]
// Port-level assertions for the dual compare timer.
`timescale 1ns/1ps
`default_nettype none
module dual_compare_timer_chk
   import dual_timer_pkg::*;
(
   input wire logic pclk, // Clock
   input wire logic presetn, // Reset
   input wire logic [7:0] paddr, // Address
   input wire logic psel, // Select
   input wire logic penable, // Enable
   input wire logic pwrite, // Direction
   input wire logic [31:0] pwdata, // Write data
   input wire logic [31:0] prdata, // Read data
   input wire logic pready, // Ready
   input wire logic pslverr, // Error
   input wire logic [1:0] match_a_request, // Match A requests
   input wire logic [1:0] match_b_request, // Match B requests
   input wire logic [1:0] wrap_request // Wrap requests
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ----------------------------------------------------------------
   // Bus handshake and request masking
   // ----------------------------------------------------------------
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_ctl_wr(a);
      psel && penable && pready && pwrite && paddr == a;
   endsequence
   property p_ready;
      s_setup |=> pready;
   endproperty
   property p_single;
      pready |=> !pready;
   endproperty
   property p_err_rdy;
      pslverr |-> pready;
   endproperty
   property p_err_data;
      pslverr && !pwrite |-> prdata == 32'h0;
   endproperty
   // Two cycles: enable lands first, the request register follows
   property p_a_off;
      s_ctl_wr(OFF_CONTROL) ##0 !pwdata[A_IE] |-> ##2 !match_a_request[0];
   endproperty
   property p_b_off;
      s_ctl_wr(OFF_CONTROL) ##0 !pwdata[B_IE] |-> ##2 !match_b_request[0];
   endproperty
   property p_w_off;
      s_ctl_wr(OFF_CONTROL) ##0 !pwdata[W_IE] |-> ##2 !wrap_request[0];
   endproperty
   property p_w1_off;
      s_ctl_wr(CH_STRIDE + OFF_CONTROL) ##0 !pwdata[W_IE] |-> ##2 !wrap_request[1];
   endproperty
   a_ready: assert property (p_ready) else $error("No ready after setup");
   a_single: assert property (p_single) else $error("Ready longer than one cycle");
   a_err_rdy: assert property (p_err_rdy) else $error("Error without ready");
   a_err_data: assert property (p_err_data) else $error("Error read data not zero");
   a_a_off: assert property (p_a_off) else $error("Match A request kept");
   a_b_off: assert property (p_b_off) else $error("Match B request kept");
   a_w_off: assert property (p_w_off) else $error("Wrap request kept");
   a_w1_off: assert property (p_w1_off) else $error("Wrap request kept");
endmodule : dual_compare_timer_chk
bind dual_compare_timer dual_compare_timer_chk u_chk (.pclk(pclk), .presetn(presetn),
   .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .match_a_request(match_a_request),
   .match_b_request(match_b_request), .wrap_request(wrap_request));
`default_nettype wire

// [bench/ext_pin_model.sv]
// Board-side driver of the external clock and clear pins.
`timescale 1ns/1ps
`default_nettype none
module ext_pin_model (
   input wire logic pclk, // System clock
   output var logic [1:0] ext_clock_in, // Clock pins
   output var logic [1:0] ext_clear_in // Clear pins
);
   // Pins rest low until a pulse
   initial
   begin
      ext_clock_in = 2'h0;
      ext_clear_in = 2'h0;
   end
   // Each level held 4 cycles, well above the minimum pulse width
   task automatic pulse(input logic clr, input int ch, input int n);
      repeat (2 * n)
      begin
         @(posedge pclk);
         if (clr)
            ext_clear_in[ch] <= ~ext_clear_in[ch];
         else
            ext_clock_in[ch] <= ~ext_clock_in[ch];
         repeat (3) @(posedge pclk);
      end
   endtask : pulse
endmodule : ext_pin_model
`default_nettype wire

// [bench/dual_compare_timer_tb.sv]
// Self-checking testbench for the dual compare timer.
`timescale 1ns/1ps
`default_nettype none
module dual_compare_timer_tb
   import dual_timer_pkg::*;
;
   logic pclk = 1'b0;
   logic presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [1:0] ext_clock_in, ext_clear_in, timer_out, match_a_request, match_b_request;
   logic [1:0] wrap_request;
   int fails = 0;
   int n_checks = 0;
   // Clock at 40 MHz
   always #12.5 pclk = ~pclk;
   dual_compare_timer u_dual_compare_timer (.pclk(pclk), .presetn(presetn), .ce(1'b1),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_clock_in(ext_clock_in),
      .ext_clear_in(ext_clear_in), .timer_out(timer_out), .match_a_request(match_a_request),
      .match_b_request(match_b_request), .wrap_request(wrap_request));
   ext_pin_model u_ext_pin_model (.pclk(pclk), .ext_clock_in(ext_clock_in),
      .ext_clear_in(ext_clear_in));
   // ----------------------------------------------------------------
   // Bus tasks; ready and read data are taken at the rising edge
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rv, exp);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   // Bounded poll for one status bit
   task automatic poll(input logic [7:0] a, input int b);
      for (int i = 0; i < 60; i++)
      begin
         apb(1'b0, a, 32'h0);
         if (rv[b] === 1'b1) break;
      end
      chk({31'h0, rv[b]}, 32'h1);
   endtask : poll
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      rd(OFF_COUNTER, 32'h0);
      rd(OFF_CONST_A, 32'hFF);
      rd(CH_STRIDE + OFF_CONST_B, 32'hFF);
   endtask : t_reset
   task automatic t_refused;
      apb(1'b0, 8'h3C, 32'h0);
      chk({31'h0, err}, 32'h1);
      wr(OFF_STATUS, 32'h10);
      rd(OFF_STATUS, 32'h0);
   endtask : t_refused
   task automatic t_word;
      wr(OFF_WORD_CONST_A, 32'h1234);
      rd(OFF_CONST_A, 32'h12);
      rd(CH_STRIDE + OFF_CONST_A, 32'h34);
      rd(OFF_WORD_CONST_A, 32'h1234);
   endtask : t_word
   task automatic t_ext;
      wr(CH_STRIDE + OFF_CONTROL, 32'h0);
      wr(CH_STRIDE + OFF_COUNTER, 32'h10);
      repeat (20) @(posedge pclk);
      rd(CH_STRIDE + OFF_COUNTER, 32'h10);
      wr(CH_STRIDE + OFF_CONTROL, 32'h05);
      u_ext_pin_model.pulse(1'b0, 1, 3);
      rd(CH_STRIDE + OFF_COUNTER, 32'h13);
      wr(CH_STRIDE + OFF_CONTROL, 32'h1D);
      u_ext_pin_model.pulse(1'b1, 1, 1);
      rd(CH_STRIDE + OFF_COUNTER, 32'h0);
   endtask : t_ext
   // Clear on match A at 3, toggle pin; stop before clearing the flag
   task automatic t_match;
      wr(OFF_CONST_A, 32'h3);
      wr(OFF_STATUS, 32'h03);
      wr(OFF_CONTROL, 32'h49);
      poll(OFF_STATUS, A_FLAG);
      wr(OFF_CONTROL, 32'h48);
      chk({30'h0, timer_out}, 32'h1);
      chk({30'h0, match_a_request}, 32'h1);
      wr(OFF_CONTROL, 32'h0);
      wr(OFF_STATUS, 32'h43);
      rd(OFF_STATUS, 32'h43);
      wr(OFF_STATUS, 32'h03);
      rd(OFF_STATUS, 32'h03);
   endtask : t_match
   task automatic t_wrap;
      wr(CH_STRIDE + OFF_COUNTER, 32'hFE);
      wr(CH_STRIDE + OFF_CONTROL, 32'hA1);
      poll(CH_STRIDE + OFF_STATUS, W_FLAG);
      chk({30'h0, wrap_request}, 32'h2);
      chk({30'h0, match_b_request}, 32'h2);
      wr(CH_STRIDE + OFF_CONTROL, 32'h0);
   endtask : t_wrap
   task automatic summarize;
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   // Main sequence, reset held 3 cycles; never both channels cascaded
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_refused();
      t_word();
      t_ext();
      t_match();
      t_wrap();
      summarize();
   end
   // Watchdog well beyond the longest expected run
   initial
   begin
      repeat (20000) @(posedge pclk);
      fails++;
      summarize();
   end
endmodule : dual_compare_timer_tb
`default_nettype wire
